//--- src/sqt_ahb_regs.sv
// AHB-Lite slave holding the configuration registers
`timescale 1ns/100ps
module sqt_ahb_regs
  import sqt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  sqt_cfg_if.regs cfg
);
  logic wr_pend;
  logic next_wr_pend;
  logic [11:0] dph_addr;
  logic [11:0] next_dph_addr;
  logic [7:0] next_slot, next_pause, next_osc, next_rel;
  logic take;
  logic [7:0] rd_byte;
  // Stall while frozen so no transfer is lost
  assign hreadyout = clk_en;
  assign hresp = 1'b0;
  assign take = hsel & htrans[1] & hready;
  always_comb begin
    next_wr_pend = take & hwrite & (hsize == 3'h2);
    next_dph_addr = take ? haddr[11:0] : dph_addr;
    next_slot = cfg.slot_sel;
    next_pause = cfg.pause_cfg;
    next_osc = cfg.osc_cfg;
    next_rel = cfg.rel_cfg;
    if (wr_pend) begin
      unique case (dph_addr)
        12'(SQT_IDX_SLOT * 4): next_slot = hwdata[7:0];
        12'(SQT_IDX_PAUSE * 4): next_pause = hwdata[7:0];
        12'(SQT_IDX_OSC * 4): next_osc = hwdata[7:0];
        12'(SQT_IDX_REL * 4): next_rel = hwdata[7:0];
        default: next_slot = cfg.slot_sel;
      endcase
    end
    if (cfg.strap_load) begin
      next_osc[SQT_XTAL_BIT] = cfg.strap_val; // R9
    end
  end
  always_comb begin
    unique case (dph_addr)
      12'(SQT_IDX_SLOT * 4): rd_byte = cfg.slot_sel;
      12'(SQT_IDX_PAUSE * 4): rd_byte = cfg.pause_cfg;
      12'(SQT_IDX_OSC * 4): rd_byte = cfg.osc_cfg;
      12'(SQT_IDX_REL * 4): rd_byte = cfg.rel_cfg;
      12'(SQT_IDX_STAT * 4): rd_byte = cfg.status;
      default: rd_byte = 8'h00;
    endcase
  end
  assign hrdata = {24'h00_0000, rd_byte};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      dph_addr <= 12'h000;
      cfg.slot_sel <= SQT_RST_SLOT;
      cfg.pause_cfg <= SQT_RST_PAUSE;
      cfg.osc_cfg <= SQT_RST_OSC;
      cfg.rel_cfg <= SQT_RST_REL;
    end else if (clk_en) begin
      wr_pend <= next_wr_pend;
      dph_addr <= next_dph_addr;
      cfg.slot_sel <= next_slot;
      cfg.pause_cfg <= next_pause;
      cfg.osc_cfg <= next_osc;
      cfg.rel_cfg <= next_rel;
    end
  end
  a_strap_load: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    cfg.strap_load && clk_en |=> cfg.osc_cfg[SQT_XTAL_BIT] == $past(cfg.strap_val))
    else $error("crystal bit not loaded from strap");
endmodule

//--- src/sqt_cfg_if.sv
// Register contents passed between the bus slave and the core
`timescale 1ns/100ps
interface sqt_cfg_if;
  logic [7:0] slot_sel;
  logic [7:0] pause_cfg;
  logic [7:0] osc_cfg;
  logic [7:0] rel_cfg;
  logic [7:0] status;
  logic strap_load;
  logic strap_val;
  modport regs (output slot_sel, pause_cfg, osc_cfg, rel_cfg,
                input status, strap_load, strap_val);
  modport core (input slot_sel, pause_cfg, osc_cfg, rel_cfg,
                output status, strap_load, strap_val);
endinterface

//--- src/sqt_pkg.sv
// Shared constants and types for the sequencer timing block
package sqt_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned SQT_CLK_HZ = 125_000_000;
  localparam int unsigned SQT_TICK_US = 512;
  localparam int unsigned SQT_TICK_CYC = SQT_TICK_US * (SQT_CLK_HZ / 1_000_000);
  localparam int unsigned SQT_TIMEOUT_MS = 500;
  // 500 ms rounded down to whole 512 us ticks
  localparam logic [14:0] SQT_TIMEOUT_TICKS = 15'(SQT_TIMEOUT_MS * 1000 / SQT_TICK_US);
  // 0.52 s settle step is 1024 ticks; 1.024 ms release step is 2 ticks
  localparam int unsigned SQT_SETTLE_SHIFT = 10;
  localparam logic [5:0] SQT_REL_SHORT_MAX = 6'h1f;
  localparam int unsigned SQT_REL_LONG_SHIFT = 6;
  // ----------------------------------------------------------------
  // Register indexes; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [9:0] SQT_IDX_SLOT = 10'h092;
  localparam logic [9:0] SQT_IDX_PAUSE = 10'h097;
  localparam logic [9:0] SQT_IDX_OSC = 10'h098;
  localparam logic [9:0] SQT_IDX_REL = 10'h099;
  localparam logic [9:0] SQT_IDX_STAT = 10'h0f0;
  localparam logic [7:0] SQT_RST_SLOT = 8'h00;
  localparam logic [7:0] SQT_RST_PAUSE = 8'h00;
  localparam logic [7:0] SQT_RST_OSC = 8'h00;
  localparam logic [7:0] SQT_RST_REL = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned SQT_TOUT_BIT = 5;
  localparam int unsigned SQT_MODE_BIT = 4;
  localparam int unsigned SQT_OUTEN_BIT = 7;
  localparam int unsigned SQT_RTCG_BIT = 6;
  localparam int unsigned SQT_OUTG_BIT = 5;
  localparam int unsigned SQT_DMODE_BIT = 4;
  localparam int unsigned SQT_XTAL_BIT = 3;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SQT_IDLE = 3'h1,
    SQT_PIN = 3'h2,
    SQT_TMR = 3'h4
  } sqt_pause_e;
  localparam logic [1:0] SQT_EVT_WAKE = 2'h0;
  localparam logic [1:0] SQT_EVT_SYS = 2'h1;
  localparam logic [1:0] SQT_EVT_PWR = 2'h2;
  localparam logic [1:0] SQT_EVT_RSTX = 2'h3;
endpackage

//--- src/sqt_seq_timing.sv
// Pause step, crystal settle gating and reset release timing
// What this block does
// R1: Direction field picks up, down or both pauses
// R2: Mode bit selects pin wait or timer
// R3: Optional 500 ms timeout on pin wait
// R4: Pause code gives 512 us doubling delays
// R5: Enable bit routes slow clock to outputs
// R6: RTC clock blocked until settle timer expires
// R7: Output clock blocked until settle timer expires
// R8: Settle start: third falling edge or crystal-on
// R9: Crystal bit loaded from strap at reset
// R10: Settle code sets crystal delay, zero is off
// R11: Event select chooses release timer trigger
// R12: Timer value N sets reset release delay
// R13: Slot field chooses the pause slot
// R14: Slot field chooses slow clock enable slot
// R15: Sequencer resumes once pause ends
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/100ps
module sqt_seq_timing
  import sqt_pkg::*;
#(
  parameter int unsigned TICK_CYC = SQT_TICK_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] slot_index,
  input wire logic slot_end,
  input wire logic seq_going_up,
  output logic seq_hold,
  input wire logic external_pause_pin,
  input wire logic osc_clk_in,
  input wire logic crystal_strap,
  input wire logic slow_clock_out_holdoff,
  output logic slow_clock_output,
  output logic rtc_clock_en,
  input wire logic external_wake,
  input wire logic system_domain_powerup,
  input wire logic power_domain_powerup,
  input wire logic reset_mode_exit,
  input wire logic reset_request,
  output logic system_reset_out_n
);
  if (TICK_CYC < 2) begin : g_bad_tick
    $error("TICK_CYC must be at least 2");
  end

  sqt_cfg_if cfg ();

  sqt_ahb_regs u_regs (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .cfg(cfg.regs)
  );

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  logic strap_done;
  logic next_strap_done;
  // Strap sampled on the first enabled edge after release
  assign cfg.strap_load = clk_en & ~strap_done;
  assign cfg.strap_val = crystal_strap;
  always_comb begin
    next_strap_done = 1'b1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done <= 1'b0;
    end else if (clk_en) begin
      strap_done <= next_strap_done;
    end
  end

  // ----------------------------------------------------------------
  // Pause step
  // ----------------------------------------------------------------
  sqt_pause_e state;
  sqt_pause_e next_state;
  logic [1:0] pause_dir;
  logic pause_tout_en;
  logic pause_timed;
  logic [3:0] pause_code;
  logic dir_ok;
  logic pause_hit;
  logic pause_go;
  logic ptmr_start;
  logic ptmr_abort;
  logic [14:0] ptmr_count;
  logic ptmr_busy;
  logic ptmr_done;

  assign pause_dir = cfg.pause_cfg[7:6];
  assign pause_tout_en = cfg.pause_cfg[SQT_TOUT_BIT];
  assign pause_timed = cfg.pause_cfg[SQT_MODE_BIT];
  assign pause_code = cfg.pause_cfg[3:0];
  assign dir_ok = seq_going_up ? pause_dir[0] : pause_dir[1]; // R1
  assign pause_hit = slot_end & (slot_index == cfg.slot_sel[3:0]) & dir_ok; // R13
  // Timed pause with code zero adds nothing beyond the slot
  assign pause_go = pause_hit & (~pause_timed | (pause_code != 4'h0)); // R4
  assign ptmr_count = pause_timed ? (15'h0001 << (pause_code - 4'h1)) // R4
                                  : SQT_TIMEOUT_TICKS; // R3

  always_comb begin
    next_state = state;
    ptmr_start = 1'b0;
    ptmr_abort = 1'b0;
    unique case (state)
      SQT_IDLE: begin
        if (pause_go) begin
          next_state = pause_timed ? SQT_TMR : SQT_PIN; // R2
          ptmr_start = pause_timed | pause_tout_en; // R3
        end
      end
      SQT_PIN: begin
        if (external_pause_pin) begin
          next_state = SQT_IDLE; // R15
          ptmr_abort = 1'b1;
        end else if (ptmr_done) begin
          next_state = SQT_IDLE; // R3
        end
      end
      SQT_TMR: begin
        if (ptmr_done) begin
          next_state = SQT_IDLE; // R15
        end
      end
      default: next_state = SQT_IDLE;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= SQT_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end
  // Held in the same cycle as slot_end so the slot never advances early
  assign seq_hold = (state != SQT_IDLE) | (state == SQT_IDLE && pause_go); // R15

  sqt_tick_timer #(.TICK_CYC(TICK_CYC), .W(15)) u_pause_tmr (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .start(ptmr_start & clk_en),
    .abort(ptmr_abort),
    .count(ptmr_count),
    .busy(ptmr_busy),
    .done(ptmr_done)
  );

  // ----------------------------------------------------------------
  // Crystal settle and slow clock gating
  // ----------------------------------------------------------------
  logic osc_prev, next_osc_prev;
  logic [1:0] fall_cnt, next_fall_cnt;
  logic xtal_prev, next_xtal_prev;
  logic settled, next_settled;
  logic slow_on, next_slow_on;
  logic next_slow_out, next_rtc_en;
  logic osc_fall;
  logic settle_start;
  logic settle_ok;
  logic [2:0] settle_code;
  logic stmr_done;

  assign settle_code = cfg.osc_cfg[2:0];
  assign osc_fall = osc_prev & ~osc_clk_in;
  assign settle_start = cfg.osc_cfg[SQT_DMODE_BIT] // R8
    ? (cfg.osc_cfg[SQT_XTAL_BIT] & ~xtal_prev)
    : (osc_fall & (fall_cnt == 2'h2));
  assign settle_ok = settled | (settle_code == 3'h0); // R10

  always_comb begin
    next_osc_prev = osc_clk_in;
    next_xtal_prev = cfg.osc_cfg[SQT_XTAL_BIT];
    next_fall_cnt = fall_cnt;
    if (osc_fall && fall_cnt != 2'h3) begin
      next_fall_cnt = fall_cnt + 2'h1; // R8
    end
    next_settled = settled;
    if (settle_start) begin
      next_settled = 1'b0;
    end else if (stmr_done) begin
      next_settled = 1'b1;
    end
    next_slow_on = slow_on;
    if (slot_end && slot_index == cfg.slot_sel[7:4]) begin
      next_slow_on = seq_going_up; // R14
    end
    next_slow_out = osc_clk_in & cfg.osc_cfg[SQT_OUTEN_BIT] & slow_on // R5
      & ~slow_clock_out_holdoff
      & (~cfg.osc_cfg[SQT_OUTG_BIT] | settle_ok); // R7
    next_rtc_en = slow_on & (~cfg.osc_cfg[SQT_RTCG_BIT] | settle_ok); // R6
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_prev <= 1'b0;
      xtal_prev <= 1'b0;
      fall_cnt <= 2'h0;
      settled <= 1'b0;
      slow_on <= 1'b0;
      slow_clock_output <= 1'b0;
      rtc_clock_en <= 1'b0;
    end else if (clk_en) begin
      osc_prev <= next_osc_prev;
      xtal_prev <= next_xtal_prev;
      fall_cnt <= next_fall_cnt;
      settled <= next_settled;
      slow_on <= next_slow_on;
      slow_clock_output <= next_slow_out;
      rtc_clock_en <= next_rtc_en;
    end
  end

  sqt_tick_timer #(.TICK_CYC(TICK_CYC), .W(15)) u_settle_tmr (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .start(settle_start & clk_en & (settle_code != 3'h0)),
    .abort(1'b0),
    .count(15'(settle_code) << SQT_SETTLE_SHIFT), // R10
    .busy(),
    .done(stmr_done)
  );

  // ----------------------------------------------------------------
  // Reset release timer
  // ----------------------------------------------------------------
  logic rel_event;
  logic [5:0] rel_n;
  logic [14:0] rtmr_count;
  logic rtmr_busy;
  logic rtmr_done;
  logic next_rst_n;

  always_comb begin
    unique case (cfg.rel_cfg[7:6])
      SQT_EVT_WAKE: rel_event = external_wake; // R11
      SQT_EVT_SYS: rel_event = system_domain_powerup;
      SQT_EVT_PWR: rel_event = power_domain_powerup;
      SQT_EVT_RSTX: rel_event = reset_mode_exit;
    endcase
  end
  assign rel_n = cfg.rel_cfg[5:0];
  assign rtmr_count = (rel_n <= SQT_REL_SHORT_MAX) // R12
    ? {8'h00, rel_n, 1'b0}
    : 15'(15'(rel_n - SQT_REL_SHORT_MAX) << SQT_REL_LONG_SHIFT);

  always_comb begin
    next_rst_n = system_reset_out_n;
    if (reset_request) begin
      next_rst_n = 1'b0;
    end else if (rel_event) begin
      next_rst_n = (rel_n == 6'h00); // R12
    end else if (rtmr_done) begin
      next_rst_n = 1'b1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      system_reset_out_n <= 1'b0;
    end else if (clk_en) begin
      system_reset_out_n <= next_rst_n;
    end
  end

  sqt_tick_timer #(.TICK_CYC(TICK_CYC), .W(15)) u_rel_tmr (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .start(rel_event & ~reset_request & clk_en & (rel_n != 6'h00)),
    .abort(reset_request | (rel_event & (rel_n == 6'h00))),
    .count(rtmr_count),
    .busy(rtmr_busy),
    .done(rtmr_done)
  );

  assign cfg.status = {5'h00, system_reset_out_n, settle_ok, state != SQT_IDLE};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_pause_dir: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    state == SQT_IDLE && slot_end && !dir_ok |-> !seq_hold)
    else $error("pause in a disabled direction");
  a_pin_release: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    state == SQT_PIN && external_pause_pin && clk_en |=> state == SQT_IDLE)
    else $error("pin wait did not end on pin");
  a_timeout_end: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    state == SQT_PIN && !pause_tout_en |-> !ptmr_busy)
    else $error("timeout running while disabled");
  a_zero_code: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    state == SQT_IDLE && pause_hit && pause_timed && pause_code == 4'h0 |-> !seq_hold)
    else $error("pause with code zero");
  a_out_gate: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    slow_clock_output && $past(cfg.osc_cfg[SQT_OUTG_BIT]) |-> $past(settle_ok))
    else $error("output clock before settle");
  a_rtc_gate: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    rtc_clock_en && $past(cfg.osc_cfg[SQT_RTCG_BIT]) |-> $past(settle_ok))
    else $error("rtc clock before settle");
  a_release_now: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    rel_event && rel_n == 6'h00 && !reset_request && clk_en |=> system_reset_out_n)
    else $error("zero delay release late");
  a_release_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    rtmr_busy |-> !system_reset_out_n)
    else $error("reset released while timing");
  a_resume_next: assert property (@(posedge hclk) disable iff (!hresetn) // R15
    state == SQT_TMR && ptmr_done |=> state == SQT_IDLE)
    else $error("no resume after pause timer");
endmodule

//--- src/sqt_tick_timer.sv
// Down counter of 512 us ticks with its own prescaler
`timescale 1ns/100ps
module sqt_tick_timer
  import sqt_pkg::*;
#(
  parameter int unsigned TICK_CYC = SQT_TICK_CYC,
  parameter int unsigned W = 15
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic start,
  input wire logic abort,
  input wire logic [W-1:0] count,
  output logic busy,
  output logic done
);
  localparam int unsigned PW = $clog2(TICK_CYC);
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYC - 1);
  if (TICK_CYC < 2) begin : g_bad_tick
    $error("TICK_CYC must be at least 2");
  end
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic [PW-1:0] pre;
  logic [PW-1:0] next_pre;
  logic next_busy;
  // Prescaler restarts on start so one tick is a full tick
  always_comb begin
    next_cnt = cnt;
    next_pre = pre;
    next_busy = busy;
    done = 1'b0;
    if (start) begin
      next_cnt = count;
      next_pre = '0;
      next_busy = (count != '0);
    end else if (abort) begin
      next_busy = 1'b0;
    end else if (busy) begin
      if (pre == PRE_LAST) begin
        next_pre = '0;
        next_cnt = cnt - W'(1);
        if (cnt == W'(1)) begin
          next_busy = 1'b0;
          done = clk_en;
        end
      end else begin
        next_pre = pre + PW'(1);
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
      pre <= '0;
      busy <= 1'b0;
    end else if (clk_en) begin
      cnt <= next_cnt;
      pre <= next_pre;
      busy <= next_busy;
    end
  end
endmodule

//--- verification/sequencer_wait_osc_reset_timing_tb_top.sv
// Self-checking bench for the sequencer timing block
`timescale 1ns/100ps
module sequencer_wait_osc_reset_timing_tb_top;
  import sqt_pkg::*;
  localparam int TCK = 4;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hwrite = 1'b0;
  logic slot_end = 1'b0;
  logic seq_going_up = 1'b0;
  logic crystal_strap = 1'b1;
  logic holdoff = 1'b0;
  logic reset_request = 1'b0;
  logic pin_en = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [3:0] slot_index = 4'h0;
  logic [3:0] evt = 4'h0;
  logic hreadyout, hresp, seq_hold, pin, osc, slow_out, rtc_en, rst_n, last_out;
  logic [31:0] hrdata;
  logic [31:0] d;
  int miscompares = 0;
  int comparisons = 0;
  int n, k, toggles;

  always #4 hclk = ~hclk;

  sqt_seq_timing #(.TICK_CYC(TCK)) dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .slot_index(slot_index), .slot_end(slot_end), .seq_going_up(seq_going_up),
    .seq_hold(seq_hold), .external_pause_pin(pin), .osc_clk_in(osc),
    .crystal_strap(crystal_strap), .slow_clock_out_holdoff(holdoff),
    .slow_clock_output(slow_out), .rtc_clock_en(rtc_en), .external_wake(evt[0]),
    .system_domain_powerup(evt[1]), .power_domain_powerup(evt[2]),
    .reset_mode_exit(evt[3]), .reset_request(reset_request), .system_reset_out_n(rst_n));

  sqt_host_model host_u (.hclk(hclk), .hresetn(hresetn), .seq_hold(seq_hold),
    .pin_en(pin_en), .pin_delay(16'h0014), .external_pause_pin(pin), .osc_clk_in(osc));

  // ----
  // Helpers
  // ----
  // Pulses last one cycle; cleared on the edge after they were raised
  always @(posedge hclk) begin
    if (slot_end) begin
      slot_end <= 1'b0;
    end
    if (evt != 4'h0) begin
      evt <= 4'h0;
    end
    if (reset_request) begin
      reset_request <= 1'b0;
    end
  end
  always @(negedge hclk) begin
    if (slow_out !== last_out) begin
      toggles++;
    end
    last_out = slow_out;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic chkr(input int lo, input int hi);
    chk({31'h0000_0000, n >= lo && n <= hi}, 32'h0000_0001);
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] v);
    @(posedge hclk);
    haddr <= {20'h0_0000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, v};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [9:0] idx, output logic [31:0] v);
    @(posedge hclk);
    haddr <= {20'h0_0000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= 1'b0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  task automatic hold_len(input logic [3:0] idx, input logic up);
    @(posedge hclk);
    slot_index <= idx;
    seq_going_up <= up;
    slot_end <= 1'b1;
    n = 0;
    @(negedge hclk);
    while (seq_hold === 1'b1 && n < 5000) begin
      n++;
      @(negedge hclk);
    end
  endtask
  task automatic rel_len(input int e, input int lim);
    @(posedge hclk);
    reset_request <= 1'b1;
    @(posedge hclk);
    evt <= 4'h1 << e;
    n = 0;
    @(negedge hclk);
    while (rst_n !== 1'b1 && n < lim) begin
      n++;
      @(negedge hclk);
    end
  endtask
  task automatic tog;
    // Output lags its controls by up to two edges
    repeat (3) @(posedge hclk);
    toggles = 0;
    repeat (64) @(posedge hclk);
  endtask
  task automatic print_verdict;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----
  // Tests
  // ----
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(SQT_IDX_OSC, d);
    chk(d, 32'h0000_0008);
    chk(hresp, 1'b0);
    rd(SQT_IDX_PAUSE, d);
    chk(d, 32'h0000_0000);
    wr(SQT_IDX_REL, 8'haa);
    rd(SQT_IDX_REL, d);
    chk(d, 32'h0000_00aa);
    wr(10'h093, 8'h5a);
    rd(10'h093, d);
    chk(d, 32'h0000_0000);
    $display("done: registers");
    wr(SQT_IDX_SLOT, 8'h21);
    for (k = 0; k < 8; k++) begin
      wr(SQT_IDX_PAUSE, {k[2:1], 2'b01, 4'h1});
      hold_len(4'h1, k[0]);
      chk({31'h0000_0000, n > 0}, {31'h0000_0000, k[0] ? k[1] : k[2]});
    end
    hold_len(4'h3, 1'b1);
    chk(n, 0);
    for (k = 0; k < 6; k++) begin
      wr(SQT_IDX_PAUSE, {4'h5, k[3:0]});
      hold_len(4'h1, 1'b1);
      if (k == 0) begin
        chk(n, 0);
      end else begin
        chkr(TCK << (k - 1), (TCK << (k - 1)) + 8);
      end
    end
    pin_en <= 1'b1;
    wr(SQT_IDX_PAUSE, 8'hc0);
    hold_len(4'h1, 1'b0);
    chkr(20, 24);
    pin_en <= 1'b0;
    wr(SQT_IDX_PAUSE, 8'he0);
    hold_len(4'h1, 1'b1);
    chkr(976 * TCK, 976 * TCK + 8);
    wr(SQT_IDX_PAUSE, 8'hc0);
    hold_len(4'h1, 1'b1);
    chk(n, 5000);
    pin_en <= 1'b1;
    repeat (30) @(negedge hclk);
    chk(seq_hold, 1'b0);
    $display("done: pause step");
    // Slow clock enabled at slot 2 going up, cleared going down
    wr(SQT_IDX_OSC, 8'h80);
    hold_len(4'h2, 1'b1);
    tog();
    chk(toggles > 0, 1'b1);
    holdoff <= 1'b1;
    tog();
    chk(toggles, 0);
    holdoff <= 1'b0;
    wr(SQT_IDX_OSC, 8'hf1);
    wr(SQT_IDX_OSC, 8'hf9);
    tog();
    chk(toggles, 0);
    chk(rtc_en, 1'b0);
    repeat (3900) @(negedge hclk);
    chk(rtc_en, 1'b0);
    repeat (300) @(negedge hclk);
    chk(rtc_en, 1'b1);
    tog();
    chk(toggles > 0, 1'b1);
    hold_len(4'h2, 1'b0);
    tog();
    chk(toggles, 0);
    hold_len(4'h2, 1'b1);
    wr(SQT_IDX_OSC, 8'ha8);
    tog();
    chk(toggles > 0, 1'b1);
    $display("done: slow clock");
    for (k = 0; k < 4; k++) begin
      wr(SQT_IDX_REL, {k[1:0], 6'h01});
      rel_len(k, 40);
      chkr(2 * TCK, 4 * TCK);
      rel_len((k + 1) % 4, 40);
      chk(n, 40);
    end
    wr(SQT_IDX_REL, 8'hc0);
    rel_len(3, 40);
    chkr(0, 2);
    wr(SQT_IDX_REL, 8'he1);
    rel_len(3, 700);
    chkr(128 * TCK, 128 * TCK + 8);
    rd(SQT_IDX_STAT, d);
    chk(d, 32'h0000_0006);
    $display("done: reset release");
    // Second reset restarts the falling-edge count for the settle start
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk(rst_n, 1'b0);
    wr(SQT_IDX_SLOT, 8'h21);
    wr(SQT_IDX_OSC, 8'h41);
    hold_len(4'h2, 1'b1);
    repeat (3900) @(negedge hclk);
    chk(rtc_en, 1'b0);
    repeat (300) @(negedge hclk);
    chk(rtc_en, 1'b1);
    $display("done: settle start");
    print_verdict();
  end

  initial begin
    repeat (60000) @(posedge hclk);
    miscompares++;
    print_verdict();
  end
endmodule

//--- verification/sqt_host_model.sv
// Host-side partner: pause pin answer and free-running slow oscillator
`timescale 1ns/100ps
module sqt_host_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic seq_hold,
  input wire logic pin_en,
  input wire logic [15:0] pin_delay,
  output logic external_pause_pin,
  output logic osc_clk_in
);
  logic [15:0] wait_cnt;
  logic [15:0] next_wait_cnt;
  logic [2:0] osc_div;
  logic [2:0] next_osc_div;
  // Pin answers only while the sequencer is held, after a chosen delay
  always_comb begin
    next_wait_cnt = seq_hold ? wait_cnt + 16'h0001 : 16'h0000;
    next_osc_div = osc_div + 3'h1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_cnt <= 16'h0000;
      osc_div <= 3'h0;
      external_pause_pin <= 1'b0;
      osc_clk_in <= 1'b0;
    end else begin
      wait_cnt <= next_wait_cnt;
      osc_div <= next_osc_div;
      external_pause_pin <= pin_en && seq_hold && (wait_cnt >= pin_delay);
      // Crystal oscillator runs free, slow against the bus clock
      if (osc_div == 3'h7) begin
        osc_clk_in <= ~osc_clk_in;
      end
    end
  end
endmodule
